// ==== ifm_decode.v ====
// Per-terminal function decode into a vector of active functions
`timescale 1ns/1ns
`include "ifm_regs.vh"
module ifm_decode #(
  parameter NUM_TERM = 10,
  parameter SEL_W = 16
)
(
  // Terminal levels and flattened selections
  input wire [NUM_TERM-1:0] i_levels,
  input wire [NUM_TERM*SEL_W-1:0] i_sel_flat,
  // One bit per function code
  output reg [`IFM_FN_COUNT-1:0] o_active
);

  // One-hot of a selection; codes out of range give nothing
  function [`IFM_FN_COUNT-1:0] code_onehot;
    input [SEL_W-1:0] code;
    integer k;
    begin
      code_onehot = {`IFM_FN_COUNT{1'b0}};
      for (k = 1; k < `IFM_FN_COUNT; k = k + 1)
      begin
        if (code == k)
          code_onehot[k] = 1'b1;
      end
    end
  endfunction

  integer t;

  // OR of all active terminals, code zero never contributes
  always @*
  begin
    o_active = {`IFM_FN_COUNT{1'b0}};
    for (t = 0; t < NUM_TERM; t = t + 1)
    begin
      if (i_levels[t])
        o_active = o_active | code_onehot(i_sel_flat[t*SEL_W +: SEL_W]);
    end
  end

endmodule

// ==== ifm_pause.v ====
// Run pause sequencer: stop while held, then pass live run requests and pulse resume marker
`timescale 1ns/1ns
module ifm_pause
(
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Pause level and run requests
  input wire i_pause,
  input wire i_fwd,
  input wire i_rev,
  // Gated run, stop request and resume marker
  output wire o_fwd,
  output wire o_rev,
  output wire o_pause_stop,
  output reg o_resume_ff
);

  localparam ST_RUN = 2'b00;
  localparam ST_PAUSED = 2'b01;
  localparam ST_RESUME = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;

  // Next state
  always @*
  begin
    case (state_ff)
      ST_RUN: nxt_state = i_pause ? ST_PAUSED : ST_RUN;
      ST_PAUSED: nxt_state = i_pause ? ST_PAUSED : ST_RESUME;
      ST_RESUME: nxt_state = i_pause ? ST_PAUSED : ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  // State and resume marker
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff <= ST_RUN;
      o_resume_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      o_resume_ff <= (state_ff == ST_PAUSED) && !i_pause;
    end
  end

  assign o_pause_stop = (state_ff == ST_PAUSED);
  assign o_fwd = o_pause_stop ? 1'b0 : i_fwd;
  assign o_rev = o_pause_stop ? 1'b0 : i_rev;

endmodule

// ==== ifm_regs.vh ====
// Register map, field positions, reset values and function codes
`ifndef IFM_REGS_VH
`define IFM_REGS_VH
// Byte offsets of the registers, function selection words one per terminal
`define IFM_FSEL_BASE 8'h00
`define IFM_FSEL_STEP 8'h04
`define IFM_CTRL_OFS 8'h28
`define IFM_STATE_OFS 8'h2C
`define IFM_INT_STATUS_OFS 8'h30
`define IFM_INT_CLEAR_OFS 8'h34
`define IFM_INT_ENABLE_OFS 8'h38
`define IFM_PULSE_CNT_OFS 8'h3C
// Control register fields
`define IFM_CTRL_PULSE_MODE 0
`define IFM_CTRL_EXP_ENABLE 1
`define IFM_CTRL_RESET 2'h0
// Function selection reset values
`define IFM_FSEL_RST_T1 16'h0001
`define IFM_FSEL_RST_T2 16'h0004
`define IFM_FSEL_RST_T3 16'h0009
`define IFM_FSEL_RST_T4 16'h000C
`define IFM_FSEL_RST_T5 16'h000D
`define IFM_FSEL_RST_EXP 16'h0000
// Function codes
`define IFM_FN_NONE 5'h00
`define IFM_FN_FWD 5'h01
`define IFM_FN_REV 5'h02
`define IFM_FN_3WIRE 5'h03
`define IFM_FN_FINCH 5'h04
`define IFM_FN_RINCH 5'h05
`define IFM_FN_UP 5'h06
`define IFM_FN_DOWN 5'h07
`define IFM_FN_COAST 5'h08
`define IFM_FN_FRESET 5'h09
`define IFM_FN_PAUSE 5'h0A
`define IFM_FN_EXTFLT 5'h0B
`define IFM_FN_MS1 5'h0C
`define IFM_FN_MS4 5'h0F
`define IFM_FN_AD1 5'h10
`define IFM_FN_AD2 5'h11
`define IFM_FN_SRCSW 5'h12
`define IFM_FN_UDCLR 5'h13
`define IFM_FN_COUNT 20
// Fault number raised by the external fault input
`define IFM_EXT_FAULT_NUM 8'h0F
// Interrupt status bits
`define IFM_INT_EXTFLT 0
`define IFM_INT_FRESET 1
`define IFM_INT_COAST 2
`define IFM_INT_PAUSE 3
`define IFM_INT_SRCSW 4
`define IFM_INT_WIDTH 5
`endif

// ==== ifm_switches.sv ====
// Switch bank model driving the digital input terminals
`timescale 1ns/1ns
module ifm_switches
(
  // Clock and requested contact states
  input wire i_mclk,
  input wire [4:0] i_std_req,
  input wire [4:0] i_exp_req,
  // Terminal levels seen by the drive
  output reg [4:0] o_std_level_ff = 5'h00,
  output reg [4:0] o_exp_level_ff = 5'h00
);
  // Contacts settle one clock after the request
  always @(posedge i_mclk)
  begin
    o_std_level_ff <= i_std_req;
    o_exp_level_ff <= i_exp_req;
  end
endmodule

// ==== ifm_top.v ====
// Digital input terminal function mapper with Wishbone registers
`timescale 1ns/1ns
`include "ifm_regs.vh"
module ifm_top #(
  parameter NUM_STD = 5,
  parameter NUM_EXP = 5,
  parameter SEL_W = 16,
  parameter ADR_W = 8
)
(
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [ADR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire o_wb_ack,
  // Terminal inputs
  input wire [NUM_STD-1:0] i_std_terminal_inputs,
  input wire [NUM_EXP-1:0] i_expansion_terminal_inputs,
  input wire i_expansion_present,
  // Drive status used for gating
  input wire i_freq_src_digital,
  input wire i_freq_from_terminal,
  input wire i_src_switch_cfg,
  // Run commands
  output reg o_forward_run_cmd_ff,
  output reg o_reverse_run_cmd_ff,
  output reg o_three_wire_mode_ff,
  output reg o_forward_inch_cmd_ff,
  output reg o_reverse_inch_cmd_ff,
  output wire o_pause_stop,
  output reg o_resume_ff,
  // Frequency commands
  output reg o_freq_up_ff,
  output reg o_freq_down_ff,
  output reg o_freq_src_alt_ff,
  output reg o_updown_clear_ff,
  output reg [3:0] o_multi_speed_idx_ff,
  output reg [1:0] o_accel_set_idx_ff,
  // Protection
  output reg o_coast_stop_ff,
  output reg o_fault_reset_ff,
  output reg o_ext_fault_ff,
  output reg [7:0] o_fault_num_ff,
  // Pulse input and interrupt
  output reg o_terminal5_pulse_ff,
  output wire o_irq
);

  localparam NUM_TERM = NUM_STD + NUM_EXP;

  // Bus and register state
  reg ack_ff;
  reg [31:0] rdat_ff;
  reg [SEL_W-1:0] fsel_ff [0:NUM_TERM-1];
  reg [1:0] ctrl_ff;
  reg [`IFM_INT_WIDTH-1:0] int_status_ff;
  reg [`IFM_INT_WIDTH-1:0] int_enable_ff;
  reg [15:0] pulse_cnt_ff;
  reg [`IFM_FN_COUNT-1:0] prev_active_ff;
  reg t5_prev_ff;

  reg [NUM_TERM*SEL_W-1:0] sel_flat;
  reg [31:0] nxt_rdat;
  reg [`IFM_INT_WIDTH-1:0] nxt_int_status;
  wire [NUM_TERM-1:0] levels;
  wire [`IFM_FN_COUNT-1:0] active;
  wire [`IFM_FN_COUNT-1:0] rise;
  wire [`IFM_INT_WIDTH-1:0] events;
  wire req;
  wire wr_req;
  wire pulse_mode;
  wire t5_level;
  wire fwd_gated;
  wire rev_gated;
  wire [ADR_W-1:0] wadr;
  integer i;
  integer f, r;

  // Reset value of each terminal selection
  function [SEL_W-1:0] fsel_reset;
    input integer idx;
    begin
      case (idx)
        0: fsel_reset = `IFM_FSEL_RST_T1;
        1: fsel_reset = `IFM_FSEL_RST_T2;
        2: fsel_reset = `IFM_FSEL_RST_T3;
        3: fsel_reset = `IFM_FSEL_RST_T4;
        4: fsel_reset = `IFM_FSEL_RST_T5;
        default: fsel_reset = `IFM_FSEL_RST_EXP;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into a stored selection word
  function [SEL_W-1:0] lane_merge;
    input [SEL_W-1:0] old;
    input [31:0] din;
    input [3:0] sel;
    reg [31:0] word;
    integer b;
    begin
      word = {{(32-SEL_W){1'b0}}, old};
      for (b = 0; b < 4; b = b + 1)
      begin
        if (sel[b])
          word[b*8 +: 8] = din[b*8 +: 8];
      end
      lane_merge = word[SEL_W-1:0];
    end
  endfunction

  // Byte address of a terminal selection word
  function [ADR_W-1:0] fsel_addr;
    input integer idx;
    begin
      fsel_addr = `IFM_FSEL_BASE + idx[ADR_W-1:0] * `IFM_FSEL_STEP;
    end
  endfunction

  // Bus request decode; word aligned addresses only
  assign req = i_wb_cyc && i_wb_stb && !ack_ff;
  assign wr_req = req && i_wb_we;
  assign wadr = {i_wb_adr[ADR_W-1:2], 2'b00};
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  // Control fields
  assign pulse_mode = ctrl_ff[`IFM_CTRL_PULSE_MODE];
  assign t5_level = i_std_terminal_inputs[NUM_STD-1];

  // expansion terminals only when the card is fitted and enabled
  // terminal five removed from level functions in pulse mode
  assign levels = {
    i_expansion_terminal_inputs &
      {NUM_EXP{i_expansion_present & ctrl_ff[`IFM_CTRL_EXP_ENABLE]}},
    t5_level & !pulse_mode,
    i_std_terminal_inputs[NUM_STD-2:0]
  };

  // Flatten selections for the decoder
  always @*
  begin
    sel_flat = {NUM_TERM*SEL_W{1'b0}};
    for (f = 0; f < NUM_TERM; f = f + 1)
      sel_flat[f*SEL_W +: SEL_W] = fsel_ff[f];
  end

  // per-terminal decode, each cycle with live selection
  ifm_decode #(
    .NUM_TERM(NUM_TERM),
    .SEL_W(SEL_W)
  ) u_decode (
    .i_levels(levels),
    .i_sel_flat(sel_flat),
    .o_active(active)
  );

  // Rising edges of decoded functions
  assign rise = active & ~prev_active_ff;

  ifm_pause u_pause (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_pause(active[`IFM_FN_PAUSE]),
    .i_fwd(active[`IFM_FN_FWD]),
    .i_rev(active[`IFM_FN_REV]),
    .o_fwd(fwd_gated),
    .o_rev(rev_gated),
    .o_pause_stop(o_pause_stop),
    .o_resume_ff(o_resume_ff)
  );

  // Selection and control register writes
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (i = 0; i < NUM_TERM; i = i + 1)
        fsel_ff[i] <= fsel_reset(i);
      ctrl_ff <= `IFM_CTRL_RESET;
      int_enable_ff <= {`IFM_INT_WIDTH{1'b0}};
    end
    else if (wr_req)
    begin
      for (i = 0; i < NUM_TERM; i = i + 1)
      begin
        if (wadr == fsel_addr(i))
          fsel_ff[i] <= lane_merge(fsel_ff[i], i_wb_dat, i_wb_sel);
      end
      if (wadr == `IFM_CTRL_OFS && i_wb_sel[0])
        ctrl_ff <= i_wb_dat[1:0];
      if (wadr == `IFM_INT_ENABLE_OFS && i_wb_sel[0])
        int_enable_ff <= i_wb_dat[`IFM_INT_WIDTH-1:0];
    end
  end

  // Read data mux; unmapped addresses read zero
  always @*
  begin
    nxt_rdat = 32'h00000000;
    for (r = 0; r < NUM_TERM; r = r + 1)
    begin
      if (wadr == fsel_addr(r))
        nxt_rdat = {16'h0000, fsel_ff[r]};
    end
    case (wadr)
      `IFM_CTRL_OFS: nxt_rdat = {30'h00000000, ctrl_ff};
      `IFM_STATE_OFS: nxt_rdat = {12'h000, active};
      `IFM_INT_STATUS_OFS: nxt_rdat = {27'h0000000, int_status_ff};
      `IFM_INT_ENABLE_OFS: nxt_rdat = {27'h0000000, int_enable_ff};
      `IFM_PULSE_CNT_OFS: nxt_rdat = {16'h0000, pulse_cnt_ff};
      default: nxt_rdat = nxt_rdat;
    endcase
  end

  // Acknowledge one cycle after the strobe, dropped the next cycle
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= req;
      if (req && !i_wb_we)
        rdat_ff <= nxt_rdat;
      else
        rdat_ff <= 32'h00000000;
    end
  end

  // Events that raise sticky interrupt bits
  assign events = {
    rise[`IFM_FN_SRCSW] & i_src_switch_cfg,
    rise[`IFM_FN_PAUSE],
    rise[`IFM_FN_COAST],
    rise[`IFM_FN_FRESET],
    rise[`IFM_FN_EXTFLT]
  };

  // Sticky status: a new event wins over a clear
  always @*
  begin
    nxt_int_status = int_status_ff;
    if (wr_req && wadr == `IFM_INT_CLEAR_OFS && i_wb_sel[0])
      nxt_int_status = nxt_int_status & ~i_wb_dat[`IFM_INT_WIDTH-1:0];
    nxt_int_status = nxt_int_status | events;
  end

  // Interrupt status register
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      int_status_ff <= {`IFM_INT_WIDTH{1'b0}};
    else
      int_status_ff <= nxt_int_status;
  end

  // Level interrupt while any enabled bit is set
  assign o_irq = |(int_status_ff & int_enable_ff);

  // Edge history and pulse counter
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prev_active_ff <= {`IFM_FN_COUNT{1'b0}};
      t5_prev_ff <= 1'b0;
      pulse_cnt_ff <= 16'h0000;
      o_terminal5_pulse_ff <= 1'b0;
    end
    else
    begin
      prev_active_ff <= active;
      t5_prev_ff <= t5_level;
      // count terminal five edges in pulse mode
      o_terminal5_pulse_ff <= pulse_mode && t5_level && !t5_prev_ff;
      if (wr_req && wadr == `IFM_PULSE_CNT_OFS)
        pulse_cnt_ff <= 16'h0000;
      else if (pulse_mode && t5_level && !t5_prev_ff)
        pulse_cnt_ff <= pulse_cnt_ff + 16'h0001;
    end
  end

  // Run and inching commands
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_forward_run_cmd_ff <= 1'b0;
      o_reverse_run_cmd_ff <= 1'b0;
      o_three_wire_mode_ff <= 1'b0;
      o_forward_inch_cmd_ff <= 1'b0;
      o_reverse_inch_cmd_ff <= 1'b0;
    end
    else
    begin
      o_forward_run_cmd_ff <= fwd_gated;
      o_reverse_run_cmd_ff <= rev_gated;
      o_three_wire_mode_ff <= active[`IFM_FN_3WIRE];
      o_forward_inch_cmd_ff <= active[`IFM_FN_FINCH];
      o_reverse_inch_cmd_ff <= active[`IFM_FN_RINCH];
    end
  end

  // Frequency commands
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_freq_up_ff <= 1'b0;
      o_freq_down_ff <= 1'b0;
      o_freq_src_alt_ff <= 1'b0;
      o_updown_clear_ff <= 1'b0;
      o_multi_speed_idx_ff <= 4'h0;
      o_accel_set_idx_ff <= 2'h0;
    end
    else
    begin
      // up/down only with digital source from terminals
      o_freq_up_ff <= active[`IFM_FN_UP] && i_freq_src_digital &&
        i_freq_from_terminal;
      o_freq_down_ff <= active[`IFM_FN_DOWN] && i_freq_src_digital &&
        i_freq_from_terminal;
      if (rise[`IFM_FN_SRCSW] && i_src_switch_cfg)
        o_freq_src_alt_ff <= !o_freq_src_alt_ff;
      o_updown_clear_ff <= rise[`IFM_FN_UDCLR] && i_freq_src_digital;
      o_multi_speed_idx_ff <= active[`IFM_FN_MS4:`IFM_FN_MS1];
      o_accel_set_idx_ff <= active[`IFM_FN_AD2:`IFM_FN_AD1];
    end
  end

  // Protection commands
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_coast_stop_ff <= 1'b0;
      o_fault_reset_ff <= 1'b0;
      o_ext_fault_ff <= 1'b0;
      o_fault_num_ff <= 8'h00;
    end
    else
    begin
      o_coast_stop_ff <= active[`IFM_FN_COAST];
      o_fault_reset_ff <= rise[`IFM_FN_FRESET];
      o_ext_fault_ff <= active[`IFM_FN_EXTFLT];
      o_fault_num_ff <= active[`IFM_FN_EXTFLT] ? `IFM_EXT_FAULT_NUM :
        8'h00;
    end
  end

endmodule

// ==== ifm_top_asserts.sv ====
// Port-level assertion checker for the input terminal function mapper
`timescale 1ns/1ns
module ifm_top_chk
(
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Bus handshake
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  // Drive status gating
  input wire i_freq_src_digital,
  input wire i_freq_from_terminal,
  input wire i_src_switch_cfg,
  // Decoded commands
  input wire o_forward_run_cmd_ff,
  input wire o_reverse_run_cmd_ff,
  input wire o_pause_stop,
  input wire o_resume_ff,
  input wire o_freq_up_ff,
  input wire o_freq_src_alt_ff,
  input wire o_updown_clear_ff,
  input wire o_fault_reset_ff,
  input wire o_ext_fault_ff,
  input wire [7:0] o_fault_num_ff
);
  // One clock domain, reset disables everything
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // Request taken, pause held for two samples
  sequence bus_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence pause_held;
    o_pause_stop ##1 o_pause_stop;
  endsequence
  chk_ack_one_cycle:
    assert property (bus_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single cycle after request");
  chk_dat_idle_zero:
    assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_fault_num_ext:
    assert property (o_fault_num_ff == (o_ext_fault_ff ? 8'h0F : 8'h00))
    else $error("fault number does not match external fault");
  chk_pause_run_off:
    assert property (pause_held |-> !o_forward_run_cmd_ff
      && !o_reverse_run_cmd_ff)
    else $error("run command active while paused");
  chk_resume_on_release:
    assert property ($fell(o_pause_stop) |-> o_resume_ff ##1 !o_resume_ff)
    else $error("resume pulse missing at pause release");
  chk_freset_one_pulse:
    assert property (o_fault_reset_ff |=> !o_fault_reset_ff)
    else $error("fault reset longer than one cycle");
  chk_up_gated_src:
    assert property (o_freq_up_ff |-> $past(i_freq_src_digital)
      && $past(i_freq_from_terminal))
    else $error("frequency up without digital terminal source");
  chk_src_toggle_cfg:
    assert property ($changed(o_freq_src_alt_ff) |-> $past(i_src_switch_cfg))
    else $error("source toggled without switching configured");
  chk_clear_one_pulse:
    assert property (o_updown_clear_ff |=> !o_updown_clear_ff)
    else $error("up/down clear longer than one cycle");
endmodule
bind ifm_top ifm_top_chk chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_freq_src_digital(i_freq_src_digital),
  .i_freq_from_terminal(i_freq_from_terminal),
  .i_src_switch_cfg(i_src_switch_cfg),
  .o_forward_run_cmd_ff(o_forward_run_cmd_ff),
  .o_reverse_run_cmd_ff(o_reverse_run_cmd_ff), .o_pause_stop(o_pause_stop),
  .o_resume_ff(o_resume_ff), .o_freq_up_ff(o_freq_up_ff),
  .o_freq_src_alt_ff(o_freq_src_alt_ff),
  .o_updown_clear_ff(o_updown_clear_ff),
  .o_fault_reset_ff(o_fault_reset_ff), .o_ext_fault_ff(o_ext_fault_ff),
  .o_fault_num_ff(o_fault_num_ff));

// ==== ifm_top_bench.sv ====
// Self-checking bench for the input terminal function mapper
`timescale 1ns/1ns
module ifm_top_bench;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [4:0] sw_std = 5'h00;
  logic [4:0] sw_exp = 5'h00;
  logic exp_on = 1'b0;
  logic digital = 1'b1;
  logic from_term = 1'b1;
  logic cfg = 1'b0;
  logic [31:0] rd;
  wire [4:0] std_lvl, exp_lvl;
  wire [31:0] rdat;
  wire [7:0] fnum;
  wire [3:0] ms;
  wire [1:0] ad;
  wire ack, forward_run_cmd, reverse_run_cmd, tw, fin, rin, pstop, resume, up, down, alt, udclr;
  wire coast, frst, ext, irq, t5p;
  integer bad_count = 0;
  integer tests_run = 0;
  integer i;
  // Function codes applied to terminal one, one row each
  logic [4:0] rows [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h08, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11};
  logic [15:0] rst_v [5] = '{16'h0001, 16'h0004, 16'h0009, 16'h000C,
    16'h000D};

  // Clock at 20 MHz
  always #25 i_mclk = ~i_mclk;

  ifm_switches sw (.i_mclk(i_mclk), .i_std_req(sw_std), .i_exp_req(sw_exp),
    .o_std_level_ff(std_lvl), .o_exp_level_ff(exp_lvl));

  ifm_top dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_std_terminal_inputs(std_lvl), .i_expansion_terminal_inputs(exp_lvl),
    .i_expansion_present(exp_on), .i_freq_src_digital(digital),
    .i_freq_from_terminal(from_term), .i_src_switch_cfg(cfg),
    .o_forward_run_cmd_ff(forward_run_cmd), .o_reverse_run_cmd_ff(reverse_run_cmd),
    .o_three_wire_mode_ff(tw), .o_forward_inch_cmd_ff(fin),
    .o_reverse_inch_cmd_ff(rin), .o_pause_stop(pstop), .o_resume_ff(resume),
    .o_freq_up_ff(up), .o_freq_down_ff(down), .o_freq_src_alt_ff(alt),
    .o_updown_clear_ff(udclr), .o_multi_speed_idx_ff(ms),
    .o_accel_set_idx_ff(ad), .o_coast_stop_ff(coast),
    .o_fault_reset_ff(frst), .o_ext_fault_ff(ext), .o_fault_num_ff(fnum),
    .o_terminal5_pulse_ff(t5p), .o_irq(irq));

  // Verdict and end of run
  task finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Value compare
  task check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic Wishbone single cycle, read data lands in rd
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    integer n;
    begin
      @(posedge i_mclk);
      cyc <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= d;
      n = 0;
      @(posedge i_mclk);
      while (ack !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge i_mclk);
      end
      rd = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      if (n == 20)
      begin
        bad_count = bad_count + 1;
        finish_test;
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Outputs gathered with bit k standing for function code k
  function logic [17:0] outs;
    outs = {ad, ms, ext, 2'b00, coast, down, up, rin, fin, tw, reverse_run_cmd, forward_run_cmd, 1'b0};
  endfunction

  function logic pick(input integer k);
    case (k)
      0: pick = frst;
      1: pick = resume;
      2: pick = alt;
      3: pick = udclr;
      default: pick = t5p;
    endcase
  endfunction

  // Bounded wait for an output, then one-cycle width check if asked
  task await(input integer k, input logic once);
    integer n;
    begin
      n = 0;
      while (pick(k) !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge i_mclk);
      end
      check("awaited output", 32'h1, {31'h0, pick(k)});
      if (once)
      begin
        @(posedge i_mclk);
        check("pulse width", 32'h0, {31'h0, pick(k)});
      end
    end
  endtask

  initial
  begin
    tick(20);
    i_sys_rst <= 1'b0;
    // Selection defaults and an unmapped place
    for (i = 0; i < 10; i++)
    begin
      wb(8'(i * 4), 1'b0, 32'h0);
      check("sel reset", (i < 5) ? {16'h0, rst_v[i]} : 32'h0, rd);
    end
    wb(8'h40, 1'b0, 32'h0);
    check("unmapped", 32'h0, rd);
    // Table of level functions on terminal one
    for (i = 0; i < 16; i++)
    begin
      wb(8'h00, 1'b1, {27'h0, rows[i]});
      sw_std <= 5'h01;
      tick(4);
      check("function", (rows[i] == 0) ? 32'h0 : 32'h1 << rows[i],
        {14'h0, outs()});
      sw_std <= 5'h00;
      tick(4);
    end
    // Frequency up blocked unless set from terminals
    wb(8'h00, 1'b1, 32'h6);
    from_term <= 1'b0;
    sw_std <= 5'h01;
    tick(4);
    check("up gated", 32'h0, {31'h0, up});
    from_term <= 1'b1;
    tick(4);
    check("up open", 32'h1, {31'h0, up});
    // Pause while running forward, then resume
    wb(8'h00, 1'b1, 32'h1);
    wb(8'h04, 1'b1, 32'hA);
    sw_std <= 5'h03;
    tick(5);
    check("paused", 32'h2, {30'h0, pstop, forward_run_cmd});
    sw_std <= 5'h01;
    await(1, 1'b1);
    tick(3);
    check("resumed", 32'h1, {30'h0, pstop, forward_run_cmd});
    // Fault reset event, interrupt masked, enabled, cleared
    sw_std <= 5'h00;
    wb(8'h34, 1'b1, 32'h1F);
    sw_std <= 5'h04;
    await(0, 1'b1);
    sw_std <= 5'h00;
    wb(8'h30, 1'b0, 32'h0);
    check("status", 32'h2, rd);
    check("irq masked", 32'h0, {31'h0, irq});
    wb(8'h38, 1'b1, 32'h2);
    tick(1);
    check("irq raised", 32'h1, {31'h0, irq});
    wb(8'h34, 1'b1, 32'h2);
    tick(1);
    check("irq cleared", 32'h0, {31'h0, irq});
    // Source switch toggle and up/down clear
    wb(8'h00, 1'b1, 32'h12);
    cfg <= 1'b1;
    sw_std <= 5'h01;
    await(2, 1'b0);
    sw_std <= 5'h00;
    wb(8'h30, 1'b0, 32'h0);
    check("status src", 32'h10, rd);
    wb(8'h00, 1'b1, 32'h13);
    sw_std <= 5'h01;
    await(3, 1'b1);
    sw_std <= 5'h00;
    // Expansion terminal six as reverse run
    wb(8'h14, 1'b1, 32'h2);
    sw_exp <= 5'h01;
    tick(4);
    check("exp off", 32'h0, {31'h0, reverse_run_cmd});
    wb(8'h28, 1'b1, 32'h2);
    exp_on <= 1'b1;
    tick(4);
    check("exp on", 32'h1, {31'h0, reverse_run_cmd});
    // Terminal five as pulse input: counted, gives no run command
    wb(8'h10, 1'b1, 32'h1);
    wb(8'h28, 1'b1, 32'h1);
    sw_std <= 5'h10;
    await(4, 1'b1);
    check("t5 no run", 32'h0, {31'h0, forward_run_cmd});
    sw_std <= 5'h00;
    wb(8'h3C, 1'b0, 32'h0);
    check("pulse count", 32'h1, rd);
    // Reset in mid-run restores selections
    i_sys_rst <= 1'b1;
    tick(3);
    i_sys_rst <= 1'b0;
    wb(8'h00, 1'b0, 32'h0);
    check("sel after reset", 32'h1, rd);
    tick(3);
    check("rev after reset", 32'h0, {31'h0, reverse_run_cmd});
    finish_test;
  end
endmodule
